// ==== hdl/dso_pkg.sv ====
// Operation
// - decorated logic store is one locked read-modify-write
// - and command writes back read and operand
// - or command writes back read or operand
// - xor command writes back read xor operand
// - decorated only when address bits 30:29 are 10
// - bits 28:26 equal 001 select and
// - bits 28:26 equal 010 select or
// - bits 28:26 equal 011 select xor
// - read and write-back keep the input size
// - bits 19:0 form the real target offset
// - don't-care address bits never affect a decorated store; undecorated accesses forward the full address
// - first address phase forwards stripped read, captures
// - next cycle reissues captured address as write
// - first data phase feeds read data and operand to the logic unit
// - first data phase registers the and, or or xor of read and operand, as the command selects
// - second data phase drives registered result out
// - input transfer stalled during read and modify
// - peripheral wait states stall the master alike
// - undecorated accesses pass through unchanged
package dso_pkg;

    // decoration fields of the input address
    localparam int unsigned DSO_SPACE_HI  = 30;
    localparam int unsigned DSO_SPACE_LO  = 29;
    localparam logic [1:0]  DSO_SPACE_PER = 2'h2;
    localparam int unsigned DSO_CMD_HI    = 28;
    localparam int unsigned DSO_CMD_LO    = 26;
    localparam int unsigned DSO_OFS_HI    = 19;
    localparam int unsigned DSO_OFS_W     = 20;

    // base of the peripheral space that the offset lands in
    localparam logic [31:0] DSO_PER_BASE = 32'h4000_0000;

    // transfer encodings of the bus
    localparam logic [1:0] DSO_TRANS_IDLE   = 2'h0;
    localparam logic [1:0] DSO_TRANS_NONSEQ = 2'h2;

    // reset values of the captured attributes
    localparam logic [DSO_OFS_W-1:0] DSO_OFS_RST  = 20'h0_0000;
    localparam logic [2:0]           DSO_SIZE_RST = 3'h0;
    localparam logic [3:0]           DSO_PROT_RST = 4'h0;
    localparam logic [31:0]          DSO_DATA_RST = 32'h0000_0000;

    // logical store commands, values as decoded from bits 28:26
    typedef enum logic [2:0] {
        dso_cmd_and = 3'h1,
        dso_cmd_or  = 3'h2,
        dso_cmd_xor = 3'h3
    } dso_cmd_t;

    // engine_addr_phase / engine_data_phase sequencing
    typedef enum logic [1:0] {
        dso_st_pass,
        dso_st_rmw_read,
        dso_st_rmw_write
    } dso_state_t;

    typedef struct packed {
        dso_state_t            state;
        dso_cmd_t              cmd;
        logic [DSO_OFS_W-1:0]  ofs;
        logic [2:0]            size;
        logic [3:0]            prot;
        logic [31:0]           data;
    } dso_regs_t;

endpackage : dso_pkg

// ==== hdl/dso_logic_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module dso_logic_unit (
    input  wire dso_pkg::dso_cmd_t i_cmd,
    input  wire logic [31:0]       i_rdata,
    input  wire logic [31:0]       i_wdata,
    output logic [31:0]            o_result
);

    // combines the fetched value with the store operand on all lanes;
    // the size of the write-back picks the lanes that really change
    always_comb begin
        case (i_cmd)
            dso_pkg::dso_cmd_and: o_result = i_rdata & i_wdata;
            dso_pkg::dso_cmd_or:  o_result = i_rdata | i_wdata;
            dso_pkg::dso_cmd_xor: o_result = i_rdata ^ i_wdata;
            default:              o_result = i_rdata;
        endcase
    end

endmodule : dso_logic_unit
`default_nettype wire

// ==== hdl/dso_engine.sv ====
`timescale 1ns/1ps
`default_nettype none
module dso_engine (
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    // input side, slave port facing the core
    input  wire logic        i_s_hsel,
    input  wire logic [31:0] i_s_haddr,
    input  wire logic [1:0]  i_s_htrans,
    input  wire logic        i_s_hwrite,
    input  wire logic [2:0]  i_s_hsize,
    input  wire logic [3:0]  i_s_hprot,
    input  wire logic [31:0] i_s_hwdata,
    input  wire logic        i_s_hready,
    output logic [31:0]      o_s_hrdata,
    output logic             o_s_hreadyout,
    output logic             o_s_hresp,
    // output side, master port facing the peripheral bridge
    output logic [31:0]      o_m_haddr,
    output logic [1:0]       o_m_htrans,
    output logic             o_m_hwrite,
    output logic [2:0]       o_m_hsize,
    output logic [3:0]       o_m_hprot,
    output logic             o_m_hmastlock,
    output logic [31:0]      o_m_hwdata,
    input  wire logic [31:0] i_m_hrdata,
    input  wire logic        i_m_hready,
    input  wire logic        i_m_hresp
);

    dso_pkg::dso_regs_t r;
    dso_pkg::dso_regs_t next_r;

    // decode of the pending input address phase
    logic       in_valid;
    logic       in_take;
    logic       is_periph;
    logic [2:0] cmd_field;
    logic       is_logic_cmd;
    logic       is_deco_store;
    logic       addr_free;
    logic [31:0] real_addr;
    logic [31:0] op_result;

    // a transfer is offered when selected and non-idle
    assign in_valid = i_s_hsel & i_s_htrans[1];

    // the previous data phase ends on i_s_hready, so the address is taken then
    assign in_take = in_valid & i_s_hready;

    // only the space bits and the command field are looked at
    assign is_periph = (i_s_haddr[dso_pkg::DSO_SPACE_HI:dso_pkg::DSO_SPACE_LO]
                        == dso_pkg::DSO_SPACE_PER);

    assign cmd_field = i_s_haddr[dso_pkg::DSO_CMD_HI:dso_pkg::DSO_CMD_LO];

    // and, or, xor are the logical stores handled here
    always_comb begin
        case (cmd_field)
            3'(dso_pkg::dso_cmd_and): is_logic_cmd = 1'b1;
            3'(dso_pkg::dso_cmd_or):  is_logic_cmd = 1'b1;
            3'(dso_pkg::dso_cmd_xor): is_logic_cmd = 1'b1;
            default:                  is_logic_cmd = 1'b0;
        endcase
    end

    // a decorated logical store; loads and other commands pass through
    assign is_deco_store = in_valid & i_s_hwrite & is_periph & is_logic_cmd;

    // strip the decoration, keeping only the offset into the space
    assign real_addr = dso_pkg::DSO_PER_BASE
                     | {12'h000, i_s_haddr[dso_pkg::DSO_OFS_HI:0]};

    // the output address bus is free except while the write is reissued
    assign addr_free = (r.state != dso_pkg::dso_st_rmw_read);

    // read data and store operand meet in the logic unit
    dso_logic_unit u_logic (
        .i_cmd    (r.cmd),
        .i_rdata  (i_m_hrdata),
        .i_wdata  (i_s_hwdata),
        .o_result (op_result)
    );

    // next-state logic of the whole engine
    always_comb begin
        next_r = r;
        case (r.state)
            dso_pkg::dso_st_pass,
            dso_pkg::dso_st_rmw_write: begin
                // a pending write-back holds the address pipe until it completes
                if (r.state == dso_pkg::dso_st_rmw_write && !i_m_hready) begin
                    next_r.state = dso_pkg::dso_st_rmw_write;
                end else if (in_take && is_deco_store) begin
                    // capture address and attributes at cycle x
                    next_r.state = dso_pkg::dso_st_rmw_read;
                    next_r.cmd   = dso_pkg::dso_cmd_t'(cmd_field);
                    next_r.ofs   = i_s_haddr[dso_pkg::DSO_OFS_HI:0];
                    next_r.size  = i_s_hsize;
                    next_r.prot  = i_s_hprot;
                end else begin
                    next_r.state = dso_pkg::dso_st_pass;
                end
            end
            dso_pkg::dso_st_rmw_read: begin
                // read data arrives when the bridge is ready; modify and hold it
                if (i_m_hready) begin
                    next_r.data  = op_result;
                    next_r.state = dso_pkg::dso_st_rmw_write;
                end else begin
                    next_r.state = dso_pkg::dso_st_rmw_read;
                end
            end
            default: begin
                next_r.state = dso_pkg::dso_st_pass;
            end
        endcase
    end

    // state register
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            r.state <= dso_pkg::dso_st_pass;
            r.cmd   <= dso_pkg::dso_cmd_and;
            r.ofs   <= dso_pkg::DSO_OFS_RST;
            r.size  <= dso_pkg::DSO_SIZE_RST;
            r.prot  <= dso_pkg::DSO_PROT_RST;
            r.data  <= dso_pkg::DSO_DATA_RST;
        end else begin
            r <= next_r;
        end
    end

    // output address phase: reissue as a locked write, else forward
    always_comb begin
        if (!addr_free) begin
            // cycle x+1: captured address recirculated as output_write
            o_m_haddr     = dso_pkg::DSO_PER_BASE
                          | {12'h000, r.ofs};
            o_m_htrans    = dso_pkg::DSO_TRANS_NONSEQ;
            o_m_hwrite    = 1'b1;
            o_m_hsize     = r.size;
            o_m_hprot     = r.prot;
            o_m_hmastlock = 1'b1;
        end else if (is_deco_store) begin
            // cycle x: input_write turned into a read of the real address
            o_m_haddr     = real_addr;
            o_m_htrans    = i_s_htrans;
            o_m_hwrite    = 1'b0;
            o_m_hsize     = i_s_hsize;
            o_m_hprot     = i_s_hprot;
            o_m_hmastlock = 1'b1;
        end else begin
            // undecorated traffic is handed on untouched
            o_m_haddr     = i_s_haddr;
            o_m_htrans    = i_s_hsel ? i_s_htrans : dso_pkg::DSO_TRANS_IDLE;
            o_m_hwrite    = i_s_hwrite;
            o_m_hsize     = i_s_hsize;
            o_m_hprot     = i_s_hprot;
            o_m_hmastlock = 1'b0;
        end
    end

    // output data phase: registered result on the write-back, else pass-through
    always_comb begin
        if (r.state == dso_pkg::dso_st_rmw_write) begin
            o_m_hwdata = r.data;
        end else begin
            o_m_hwdata = i_s_hwdata;
        end
    end

    // input answer: stall through the read, then mirror the bridge
    always_comb begin
        o_s_hrdata = i_m_hrdata;
        if (r.state == dso_pkg::dso_st_rmw_read) begin
            o_s_hreadyout = 1'b0;
            o_s_hresp     = 1'b0;
        end else begin
            o_s_hreadyout = i_m_hready;
            o_s_hresp     = i_m_hresp;
        end
    end

endmodule : dso_engine
`default_nettype wire

// ==== sim/dso_engine_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module dso_engine_assertions (
    input wire logic        i_clk,
    input wire logic        i_arst_n,
    input wire logic        i_s_hsel,
    input wire logic [31:0] i_s_haddr,
    input wire logic [1:0]  i_s_htrans,
    input wire logic        i_s_hwrite,
    input wire logic [2:0]  i_s_hsize,
    input wire logic [3:0]  i_s_hprot,
    input wire logic [31:0] i_s_hwdata,
    input wire logic        i_s_hready,
    input wire logic        o_s_hreadyout,
    input wire logic [31:0] o_s_hrdata,
    input wire logic [31:0] o_m_haddr,
    input wire logic [1:0]  o_m_htrans,
    input wire logic        o_m_hwrite,
    input wire logic [2:0]  o_m_hsize,
    input wire logic [3:0]  o_m_hprot,
    input wire logic        o_m_hmastlock,
    input wire logic [31:0] o_m_hwdata,
    input wire logic [31:0] i_m_hrdata,
    input wire logic        i_m_hready
);
    logic        acc;
    logic        dec;
    logic [2:0]  cmd;
    logic [31:0] ra;
    // accepted transfer, decorated logic store and its stripped address
    assign acc = i_s_hsel && i_s_htrans[1] && i_s_hready;
    assign cmd = i_s_haddr[28:26];
    assign dec = acc && i_s_hwrite && i_s_haddr[30:29] == 2'h2 && cmd inside {3'h1, 3'h2, 3'h3};
    assign ra = {12'h400, i_s_haddr[19:0]};
    function automatic logic [31:0] op(input logic [2:0] c, input logic [31:0] r, w);
        return c == 3'h1 ? r & w : (c == 3'h2 ? r | w : r ^ w);
    endfunction : op
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    read_conv_a: assert property (dec |-> !o_m_hwrite && o_m_haddr == ra)
        else $error("decorated store not sent as read");
    reissue_wr_a: assert property (dec |=> o_m_hwrite && o_m_htrans == 2'h2
        && o_m_haddr == $past(ra))
        else $error("write not reissued");
    stall_in_a: assert property (dec |=> !o_s_hreadyout)
        else $error("input not stalled");
    lock_hold_a: assert property (dec |-> o_m_hmastlock ##1 o_m_hmastlock)
        else $error("lock dropped inside sequence");
    size_keep_a: assert property (dec |=> o_m_hsize == $past(i_s_hsize))
        else $error("write size differs");
    wait_pass_a: assert property (!i_m_hready |-> !o_s_hreadyout)
        else $error("wait state not passed back");
    plain_pass_a: assert property (acc && !dec |-> o_m_haddr == i_s_haddr
        && o_m_hwrite == i_s_hwrite && !o_m_hmastlock)
        else $error("plain access altered");
    result_data_a: assert property (dec ##1 i_m_hready |=>
        o_m_hwdata == op($past(cmd, 2), $past(i_m_hrdata), $past(i_s_hwdata)))
        else $error("write data not the combined value");
    rdata_pass_a: assert property (o_s_hrdata == i_m_hrdata)
        else $error("read data not mirrored");
    attr_keep_a: assert property (dec |=> o_m_hprot == $past(i_s_hprot))
        else $error("write attributes differ");
    cover property (dec && cmd == 3'h3);
    cover property (dec ##1 !i_m_hready);
    cover property (acc && !dec && i_s_hwrite);
endmodule : dso_engine_assertions
bind dso_engine dso_engine_assertions chk (.*);
`default_nettype wire

// ==== sim/dso_periph_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dso_periph_model (
    input  wire logic        i_clk,
    input  wire logic        i_arst_n,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic [1:0]  i_waits,
    output logic [31:0]      o_hrdata,
    output logic             o_hready,
    output logic             o_hresp
);
    logic [31:0] mem [16];
    logic        act;
    logic        wr;
    logic [5:0]  a;
    logic [2:0]  sz;
    logic [1:0]  cnt;
    logic [31:0] m;
    // ready once the wait states of the data phase are spent
    assign o_hready = !act || cnt == 2'h0;
    assign o_hresp = 1'b0;
    // read data only in a finished read phase, else the inverse word
    assign o_hrdata = (act && !wr && o_hready) ? mem[a[5:2]] : ~mem[a[5:2]];
    assign m = sz == 3'h0 ? 32'h0000_00ff << {a[1:0], 3'h0} :
               (sz == 3'h1 ? 32'h0000_ffff << {a[1], 4'h0} : 32'hffff_ffff);
    // data phase bookkeeping and lane write
    always @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            act <= 1'b0;
            cnt <= 2'h0;
        end else if (o_hready) begin
            if (act && wr) mem[a[5:2]] <= (mem[a[5:2]] & ~m) | (i_hwdata & m);
            act <= i_htrans[1];
            wr <= i_hwrite;
            a <= i_haddr[5:0];
            sz <= i_hsize;
            cnt <= i_waits;
        end else begin
            cnt <= cnt - 2'h1;
        end
    end
endmodule : dso_periph_model
`default_nettype wire

// ==== sim/tb_decorated_store_logic_ops.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin errors++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module tb_decorated_store_logic_ops;
    logic        i_clk, i_arst_n, hsel, hwrite, s_rdy, m_rdy, m_resp, m_wr;
    logic [31:0] haddr, hwdata, m_rdata, m_addr, m_wdata, s_rdata;
    logic [1:0]  htrans, m_trans, waits;
    logic [2:0]  hsize, m_size;
    int          errors, comparisons;
    dso_engine dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_s_hsel(hsel), .i_s_haddr(haddr),
        .i_s_htrans(htrans), .i_s_hwrite(hwrite), .i_s_hsize(hsize), .i_s_hprot(4'h1),
        .i_s_hwdata(hwdata), .i_s_hready(s_rdy), .o_s_hrdata(s_rdata), .o_s_hreadyout(s_rdy),
        .o_s_hresp(), .o_m_haddr(m_addr), .o_m_htrans(m_trans), .o_m_hwrite(m_wr),
        .o_m_hsize(m_size), .o_m_hprot(), .o_m_hmastlock(), .o_m_hwdata(m_wdata),
        .i_m_hrdata(m_rdata), .i_m_hready(m_rdy), .i_m_hresp(m_resp));
    dso_periph_model pm (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_haddr(m_addr),
        .i_htrans(m_trans), .i_hwrite(m_wr), .i_hsize(m_size), .i_hwdata(m_wdata),
        .i_waits(waits), .o_hrdata(m_rdata), .o_hready(m_rdy), .o_hresp(m_resp));
    // expected word after a store of replicated data d
    function automatic logic [31:0] rmw(input logic [31:0] o, d, input logic [2:0] c, sz,
                                        input logic [1:0] lo);
        logic [31:0] m, r;
        m = sz == 3'h0 ? 32'h0000_00ff << {lo, 3'h0} :
            (sz == 3'h1 ? 32'h0000_ffff << {lo[1], 4'h0} : 32'hffff_ffff);
        r = c == 3'h1 ? o & d : (c == 3'h2 ? o | d : (c == 3'h3 ? o ^ d : d));
        return (o & ~m) | (r & m);
    endfunction : rmw
    task automatic give_verdict;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict
    // one store with command c; stall cycles and target word judged
    task automatic store(input logic [31:0] a, d, input logic [2:0] sz, c, input int st);
        logic [31:0] e;
        int n;
        n = 0;
        pm.mem[a[5:2]] = 32'hf0f0_a5a5;
        e = rmw(32'hf0f0_a5a5, d, c, sz, a[1:0]);
        @(posedge i_clk);
        haddr <= a;
        htrans <= 2'h2;
        hsize <= sz;
        @(posedge i_clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(negedge i_clk);
        while (s_rdy !== 1'b1 && n < 20) begin
            n++;
            @(negedge i_clk);
        end
        @(negedge i_clk);
        `CHK("stall cycles", st, n)
        if (n == 20) give_verdict();
        `CHK("target word", e, pm.mem[a[5:2]])
    endtask : store
    // one load, plain or decorated; it passes through and leaves the word alone
    task automatic load(input logic [31:0] a);
        int n;
        n = 0;
        pm.mem[a[5:2]] = 32'h5a5a_0ff0;
        @(posedge i_clk);
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= 1'b0;
        hsize <= 3'h2;
        @(posedge i_clk);
        htrans <= 2'h0;
        hwrite <= 1'b1;
        @(negedge i_clk);
        while (s_rdy !== 1'b1 && n < 20) begin
            n++;
            @(negedge i_clk);
        end
        `CHK("load stalls", 1, n)
        if (n == 20) give_verdict();
        `CHK("load data", 32'h5a5a_0ff0, s_rdata)
        @(negedge i_clk);
        `CHK("load leaves word", 32'h5a5a_0ff0, pm.mem[a[5:2]])
    endtask : load
    task automatic t_logic_word;
        store(32'h47f0_0004, 32'h3c3c_ff00, 3'h2, 3'h1, 1);
        store(32'h4bf0_0004, 32'h3c3c_ff00, 3'h2, 3'h2, 1);
        store(32'h4ff0_0004, 32'h3c3c_ff00, 3'h2, 3'h3, 1);
        $display("word logic stores done");
    endtask : t_logic_word
    task automatic t_loads;
        waits <= 2'h1;
        load(32'h4000_0010);
        load(32'h4400_0010);
        $display("plain and decorated loads done");
    endtask : t_loads
    task automatic t_narrow_wait;
        waits <= 2'h1;
        store(32'h4c00_0006, {4{8'h5a}}, 3'h0, 3'h3, 3);
        store(32'h4800_0006, {2{16'h0ff0}}, 3'h1, 3'h2, 3);
        waits <= 2'h2;
        store(32'h4400_0008, 32'h00ff_00ff, 3'h2, 3'h1, 5);
        $display("narrow and wait stores done");
    endtask : t_narrow_wait
    task automatic t_plain;
        waits <= 2'h1;
        store(32'h2c00_000c, 32'h1234_5678, 3'h2, 3'h0, 1);
        store(32'h6c00_000c, 32'h1234_5678, 3'h2, 3'h0, 1);
        store(32'h4000_000c, 32'h1234_5678, 3'h2, 3'h0, 1);
        $display("plain writes done");
    endtask : t_plain
    // clock
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    // reset, then the scenarios
    initial begin
        {i_arst_n, htrans, hsize, haddr, hwdata, waits} = '0;
        hsel = 1'b1;
        hwrite = 1'b1;
        repeat (5) @(posedge i_clk);
        i_arst_n <= 1'b1;
        t_logic_word();
        t_narrow_wait();
        t_plain();
        t_loads();
        give_verdict();
    end
endmodule : tb_decorated_store_logic_ops
`default_nettype wire
